/* mds_top.sv */
// Dual-axis driver status words, protection latches and register port
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "mds_defines.svh"
module mds_top
  import mds_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire mds_bus_req_s bus,
  output logic [31:0] reg_rdata,
  input wire mds_pins_s pins,
  input wire mds_axis_meas_s [1:0] axis_meas,
  output logic [1:0] driver_on,
  output logic irq
);

  function automatic logic hit(
    input logic [`MDS_ADDR_W-1:0] a,
    input logic [7:0] idx
  );
    hit = (a == {idx, 2'b00});
  endfunction : hit

  // Pin inputs: three stages, the first is read only by the second
  logic [`MDS_PINS_W-1:0] sync1;
  logic [`MDS_PINS_W-1:0] sync2;
  logic [`MDS_PINS_W-1:0] sync3;
  mds_pins_s pins_filt;
  mds_pins_s next_pins_filt;
  logic [`MDS_PINS_W-1:0] sync_agree;

  assign sync_agree = ~(sync2 ^ sync3);
  // A change counts only once stages two and three agree
  assign next_pins_filt = (sync3 & sync_agree) | (pins_filt & ~sync_agree);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1 <= `MDS_PINS_RST;
      sync2 <= `MDS_PINS_RST;
      sync3 <= `MDS_PINS_RST;
      pins_filt <= `MDS_PINS_RST;
    end else if (clk_en) begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
      pins_filt <= next_pins_filt;
    end
  end

  // Thermal shutdown; one instance serves both axes
  mds_therm_e therm;
  mds_therm_e next_therm;
  mds_thermal_s thermal;

  always_comb begin
    next_therm = therm;
    case (therm)
      MDS_TH_COOL: begin
        if (pins_filt.overheat_hot) begin
          next_therm = MDS_TH_SHUT;
        end
      end
      MDS_TH_SHUT: begin
        // Limit alone falling is not enough; the pre-warning must clear too
        if (!pins_filt.overheat_hot && !pins_filt.prewarn_hot) begin
          next_therm = MDS_TH_COOL;
        end
      end
      default: begin
        next_therm = MDS_TH_SHUT;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      therm <= MDS_TH_COOL;
    end else if (clk_en) begin
      therm <= next_therm;
    end
  end

  assign thermal.prewarn = pins_filt.prewarn_hot;
  assign thermal.shutdown = (therm == MDS_TH_SHUT);

  // Register decode
  logic [1:0] wr_ctrl;
  logic wr_irq_status;
  logic wr_irq_mask;
  logic hit_status1;
  logic hit_status2;
  logic hit_ctrl1;
  logic hit_ctrl2;
  logic hit_irq_status;
  logic hit_irq_mask;

  assign hit_status1 = hit(bus.addr, `MDS_IDX_STATUS_AX1);
  assign hit_status2 = hit(bus.addr, `MDS_IDX_STATUS_AX2);
  assign hit_ctrl1 = hit(bus.addr, `MDS_IDX_CTRL_AX1);
  assign hit_ctrl2 = hit(bus.addr, `MDS_IDX_CTRL_AX2);
  assign hit_irq_status = hit(bus.addr, `MDS_IDX_IRQ_STATUS);
  assign hit_irq_mask = hit(bus.addr, `MDS_IDX_IRQ_MASK);
  assign wr_ctrl[0] = bus.wr & hit_ctrl1;
  assign wr_ctrl[1] = bus.wr & hit_ctrl2;
  assign wr_irq_status = bus.wr & hit_irq_status;
  assign wr_irq_mask = bus.wr & hit_irq_mask;
  // Status words have no write decode at all, so writes there vanish

  // Per-axis control: off time and load speed mode
  mds_axis_ctrl_s [1:0] ctrl;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl[0] <= `MDS_CTRL_RST;
      ctrl[1] <= `MDS_CTRL_RST;
    end else if (clk_en) begin
      if (wr_ctrl[0]) begin
        ctrl[0] <= bus.wdata[`MDS_CTRL_W-1:0];
      end
      if (wr_ctrl[1]) begin
        ctrl[1] <= bus.wdata[`MDS_CTRL_W-1:0];
      end
    end
  end

  // Axis instances
  logic [31:0] word [2];
  logic [1:0] short_ev;
  logic [1:0] stall_ev;

  for (genvar i = 0; i < 2; i++) begin : g_axis
    mds_axis_pins_s apins;
    assign apins.open_load_b = pins_filt.open_load_b[i];
    assign apins.open_load_a = pins_filt.open_load_a[i];
    assign apins.short_b = pins_filt.short_b_det[i];
    assign apins.short_a = pins_filt.short_a_det[i];
    mds_axis_status u_axis (
      .ref_clk(ref_clk),
      .rst(rst),
      .clk_en(clk_en),
      .ctrl(ctrl[i]),
      .driver_enable_low_pin(pins_filt.driver_enable_low_pin),
      .thermal(thermal),
      .apins(apins),
      .meas(axis_meas[i]),
      .status_word(word[i]),
      .driver_on(driver_on[i]),
      .short_event(short_ev[i]),
      .stall_event(stall_ev[i])
    );
  end

  // Interrupts: sticky events, write one to clear, set beats clear
  logic [`MDS_IRQ_W-1:0] irq_status;
  logic [`MDS_IRQ_W-1:0] irq_mask;
  logic [`MDS_IRQ_W-1:0] irq_events;
  logic [`MDS_IRQ_W-1:0] irq_clr;
  logic [`MDS_IRQ_W-1:0] next_irq_status;

  assign irq_events[`MDS_IRQ_SHORT0] = short_ev[0];
  assign irq_events[`MDS_IRQ_SHORT1] = short_ev[1];
  assign irq_events[`MDS_IRQ_STALL0] = stall_ev[0];
  assign irq_events[`MDS_IRQ_STALL1] = stall_ev[1];
  assign irq_events[`MDS_IRQ_OVERHEAT] = (next_therm == MDS_TH_SHUT) && (therm == MDS_TH_COOL);
  assign irq_events[`MDS_IRQ_PREWARN] = next_pins_filt.prewarn_hot & ~pins_filt.prewarn_hot;
  assign irq_clr = wr_irq_status ? bus.wdata[`MDS_IRQ_W-1:0] : `MDS_IRQ_RST;
  assign next_irq_status = (irq_status & ~irq_clr) | irq_events;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_status <= `MDS_IRQ_RST;
      irq_mask <= `MDS_IRQ_RST;
    end else if (clk_en) begin
      irq_status <= next_irq_status;
      if (wr_irq_mask) begin
        irq_mask <= bus.wdata[`MDS_IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  // Read path; selection has no side effect on any flag
  logic [31:0] rd_sel;

  assign rd_sel = hit_status1 ? word[0] :
                  hit_status2 ? word[1] :
                  hit_ctrl1 ? {27'h0, ctrl[0]} :
                  hit_ctrl2 ? {27'h0, ctrl[1]} :
                  hit_irq_status ? {26'h0, irq_status} :
                  hit_irq_mask ? {26'h0, irq_mask} :
                  32'h0;

  // Data stand in the cycle after a strobe taken with clk_en high, zero after other enabled cycles, held while clk_en is low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= 32'h0;
    end else if (clk_en) begin
      reg_rdata <= bus.rd ? rd_sel : 32'h0;
    end
  end

  // Checks
  sequence s_overheat_seen;
    clk_en && pins_filt.overheat_hot;
  endsequence

  sequence s_still_warm;
    clk_en && pins_filt.prewarn_hot;
  endsequence

  a_thermal_common: assert property (@(posedge ref_clk) disable iff (rst)
    word[0][`MDS_BIT_PREWARN:`MDS_BIT_OVERHEAT] == word[1][`MDS_BIT_PREWARN:`MDS_BIT_OVERHEAT])
    else $error("thermal bits differ between axes");

  a_overheat_hold: assert property (@(posedge ref_clk) disable iff (rst)
    s_overheat_seen ##1 s_still_warm |=> driver_on == 2'b00)
    else $error("driver on during overheat shutdown");

  a_status_read: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en && bus.rd && hit_status2) |=> reg_rdata == $past(word[1]))
    else $error("second axis word read back wrong");

  a_rdata_idle: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en && !bus.rd) |=> reg_rdata == 32'h0)
    else $error("read data present without a read");

  a_irq_set_wins: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en && wr_irq_status && bus.wdata[`MDS_IRQ_SHORT0] && short_ev[0])
    |=> irq_status[`MDS_IRQ_SHORT0])
    else $error("short event lost against a clear");

  sequence s_read_status1;
    clk_en && bus.rd && hit_status1;
  endsequence

  a_status1_read: assert property (@(posedge ref_clk) disable iff (rst)
    s_read_status1 |=> reg_rdata == $past(word[0]))
    else $error("first axis word read back wrong");

  a_read_no_clear: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en && bus.rd && hit_status1 && word[0][`MDS_BIT_SHORT_A]
     && ctrl[0].off_time != 4'h0 && !pins_filt.driver_enable_low_pin)
    |=> word[0][`MDS_BIT_SHORT_A])
    else $error("reading the status word cleared a short flag");

  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (rst)
    word[0][`MDS_BIT_STALL-1:`MDS_CS_MSB+1] == 3'h0 && word[0][`MDS_CS_LSB-1:0] == 16'h0
    && word[1][`MDS_BIT_STALL-1:`MDS_CS_MSB+1] == 3'h0 && word[1][`MDS_CS_LSB-1:0] == 16'h0)
    else $error("reserved status bits not zero");

  a_status_no_write: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en && bus.wr && (hit_status1 || hit_status2)) |=> $stable(ctrl) && $stable(irq_mask))
    else $error("write to a status word changed a register");

  a_ctrl_write: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en && wr_ctrl[0]) |=> ctrl[0] == $past(bus.wdata[`MDS_CTRL_W-1:0]))
    else $error("control word of the first axis not written");

  a_off_time_zero1: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en && ctrl[0].off_time == 4'h0) |=> !driver_on[0])
    else $error("first axis driving with zero off time");

  a_off_time_zero2: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en && ctrl[1].off_time == 4'h0) |=> !driver_on[1])
    else $error("second axis driving with zero off time");

  a_enable_pin_off: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en && pins_filt.driver_enable_low_pin) |=> driver_on == 2'b00)
    else $error("driver on while the enable pin is high");

  a_pin_filter: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en && sync2 == sync3) |=> pins_filt == $past(sync3))
    else $error("filtered pins do not follow agreeing stages");

  a_therm_onehot: assert property (@(posedge ref_clk) disable iff (rst)
    $onehot(therm))
    else $error("thermal state not one-hot");

  a_overheat_exit: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en && therm == MDS_TH_SHUT && pins_filt.prewarn_hot) |=> therm == MDS_TH_SHUT)
    else $error("overheat shutdown left while still warm");

  a_irq_w1c: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en && wr_irq_status && bus.wdata[`MDS_IRQ_SHORT0] && !short_ev[0])
    |=> !irq_status[`MDS_IRQ_SHORT0])
    else $error("short interrupt not cleared by a write of one");

  a_clk_en_freeze: assert property (@(posedge ref_clk) disable iff (rst)
    !clk_en |=> $stable(reg_rdata) && $stable(driver_on)
    && $stable(irq_status) && $stable(therm))
    else $error("state moved while the clock enable was low");

endmodule : mds_top

/* mds_defines.svh */
// Register indices, field positions and reset values of the driver status block
`ifndef MDS_DEFINES_SVH
`define MDS_DEFINES_SVH
`define MDS_ADDR_W 10
`define MDS_IDX_STATUS_AX1 8'h6F
`define MDS_IDX_STATUS_AX2 8'h7F
`define MDS_IDX_CTRL_AX1 8'h60
`define MDS_IDX_CTRL_AX2 8'h70
`define MDS_IDX_IRQ_STATUS 8'h40
`define MDS_IDX_IRQ_MASK 8'h41
`define MDS_BIT_STANDSTILL 31
`define MDS_BIT_OPEN_B 30
`define MDS_BIT_OPEN_A 29
`define MDS_BIT_SHORT_B 28
`define MDS_BIT_SHORT_A 27
`define MDS_BIT_PREWARN 26
`define MDS_BIT_OVERHEAT 25
`define MDS_BIT_STALL 24
`define MDS_CS_MSB 20
`define MDS_CS_LSB 16
`define MDS_CS_W 5
`define MDS_LOAD_W 10
`define MDS_CTRL_W 5
`define MDS_CTRL_RST 5'h00
`define MDS_PINS_W 11
`define MDS_PINS_RST 11'h400
`define MDS_IRQ_W 6
`define MDS_IRQ_RST 6'h00
`define MDS_IRQ_SHORT0 0
`define MDS_IRQ_SHORT1 1
`define MDS_IRQ_STALL0 2
`define MDS_IRQ_STALL1 3
`define MDS_IRQ_OVERHEAT 4
`define MDS_IRQ_PREWARN 5
`endif

/* mds_pkg.sv */
// Types shared by the driver status block
`include "mds_defines.svh"
package mds_pkg;
  typedef struct packed {
    logic [`MDS_ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } mds_bus_req_s;
  typedef struct packed {
    logic driver_enable_low_pin;
    logic overheat_hot;
    logic prewarn_hot;
    logic [1:0] open_load_b;
    logic [1:0] open_load_a;
    logic [1:0] short_b_det;
    logic [1:0] short_a_det;
  } mds_pins_s;
  typedef struct packed {
    logic open_load_b;
    logic open_load_a;
    logic short_b;
    logic short_a;
  } mds_axis_pins_s;
  typedef struct packed {
    logic standstill;
    logic [`MDS_LOAD_W-1:0] load_measurement_result;
    logic speed_stall;
    logic [`MDS_CS_W-1:0] current_scale;
  } mds_axis_meas_s;
  typedef struct packed {
    logic load_speed_mode;
    logic [3:0] off_time;
  } mds_axis_ctrl_s;
  typedef struct packed {
    logic prewarn;
    logic shutdown;
  } mds_thermal_s;
  typedef enum logic [1:0] {
    MDS_TH_COOL = 2'b01,
    MDS_TH_SHUT = 2'b10
  } mds_therm_e;
endpackage : mds_pkg

/* mds_axis_status.sv */
// One axis: ground-short latches, stall flag, driver gate and status word
`timescale 1ns/1ps
`include "mds_defines.svh"
module mds_axis_status
  import mds_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire mds_axis_ctrl_s ctrl,
  input wire logic driver_enable_low_pin,
  input wire mds_thermal_s thermal,
  input wire mds_axis_pins_s apins,
  input wire mds_axis_meas_s meas,
  output logic [31:0] status_word,
  output logic driver_on,
  output logic short_event,
  output logic stall_event
);
  logic short_a;
  logic short_b;
  logic stall_q;
  logic [31:0] next_word;
  wire user_off = (ctrl.off_time == 4'h0) || driver_enable_low_pin;
  // Set wins: a short seen while being disabled stays latched
  wire next_short_a = apins.short_a | (short_a & ~user_off);
  wire next_short_b = apins.short_b | (short_b & ~user_off);
  wire load_zero = (meas.load_measurement_result == `MDS_LOAD_W'h0);
  wire stall_now = load_zero | (ctrl.load_speed_mode & meas.speed_stall);
  // Open-load bits are not part of the gate on purpose
  wire next_on = ~user_off & ~next_short_a & ~next_short_b & ~thermal.shutdown;

  always_comb begin
    next_word = 32'h0;
    next_word[`MDS_BIT_STANDSTILL] = meas.standstill;
    next_word[`MDS_BIT_OPEN_B] = apins.open_load_b;
    next_word[`MDS_BIT_OPEN_A] = apins.open_load_a;
    next_word[`MDS_BIT_SHORT_B] = next_short_b;
    next_word[`MDS_BIT_SHORT_A] = next_short_a;
    next_word[`MDS_BIT_PREWARN] = thermal.prewarn;
    next_word[`MDS_BIT_OVERHEAT] = thermal.shutdown;
    next_word[`MDS_BIT_STALL] = stall_now;
    next_word[`MDS_CS_MSB:`MDS_CS_LSB] = meas.current_scale;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      short_a <= 1'b0;
      short_b <= 1'b0;
      stall_q <= 1'b0;
      driver_on <= 1'b0;
      status_word <= 32'h0;
    end else if (clk_en) begin
      short_a <= next_short_a;
      short_b <= next_short_b;
      stall_q <= stall_now;
      driver_on <= next_on;
      status_word <= next_word;
    end
  end

  assign short_event = (next_short_a & ~short_a) | (next_short_b & ~short_b);
  assign stall_event = stall_now & ~stall_q;

  a_short_gate: assert property (@(posedge ref_clk) disable iff (rst)
    (short_a | short_b) |-> !driver_on)
    else $error("driver on while a ground short is latched");
  a_short_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en && short_a && !user_off) |=> short_a)
    else $error("ground short flag dropped while driver enabled");
  a_short_release: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en && short_b && user_off && !apins.short_b) |=> !short_b)
    else $error("ground short flag kept after driver disable");
  a_open_no_action: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en && !user_off && !thermal.shutdown && !apins.short_a && !apins.short_b
     && !short_a && !short_b) |=> driver_on)
    else $error("driver off without a protective cause");
  a_stall_zero: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en && load_zero) |=> status_word[`MDS_BIT_STALL])
    else $error("zero load result did not flag a stall");
  a_standstill_bit: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en |=> status_word[`MDS_BIT_STANDSTILL] == $past(meas.standstill))
    else $error("standstill bit does not follow the motor");
endmodule : mds_axis_status

/* mds_coil_model.sv */
// Two coil pairs: faults are sensed only while the bridges drive current
`timescale 1ns/1ps
module mds_coil_model
  import mds_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [1:0] driver_on,
  input wire logic [1:0] open_b,
  input wire logic [1:0] open_a,
  input wire logic [1:0] gnd_b,
  input wire logic [1:0] gnd_a,
  output logic [1:0] open_load_b,
  output logic [1:0] open_load_a,
  output logic [1:0] short_b_det,
  output logic [1:0] short_a_det
);
  // An idle bridge carries no current, so a broken or grounded coil stays invisible
  always_ff @(posedge ref_clk) begin
    open_load_b <= open_b & driver_on;
    open_load_a <= open_a & driver_on;
    short_b_det <= gnd_b & driver_on;
    short_a_det <= gnd_a & driver_on;
  end
endmodule : mds_coil_model

/* mds_top_tb.sv */
// Self-checking bench for the dual-axis driver status block
`timescale 1ns/1ps
`include "mds_defines.svh"
module mds_top_tb
  import mds_pkg::*;
;
  localparam logic [31:0] AX1 = (32'h1 << `MDS_BIT_STANDSTILL) | (32'h15 << `MDS_CS_LSB);
  localparam logic [31:0] AX2 = 32'h0A << `MDS_CS_LSB;
  localparam logic [31:0] B_STALL = 32'h1 << `MDS_BIT_STALL;
  localparam logic [31:0] B_OB = 32'h1 << `MDS_BIT_OPEN_B;
  localparam logic [31:0] B_OA = 32'h1 << `MDS_BIT_OPEN_A;
  localparam logic [31:0] B_SB = 32'h1 << `MDS_BIT_SHORT_B;
  localparam logic [31:0] B_SA = 32'h1 << `MDS_BIT_SHORT_A;
  localparam logic [31:0] B_PW = 32'h1 << `MDS_BIT_PREWARN;
  localparam logic [31:0] B_HOT = 32'h1 << `MDS_BIT_OVERHEAT;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  mds_bus_req_s bus = '0;
  logic [31:0] reg_rdata;
  logic [1:0] driver_on;
  logic irq;
  logic en_low = 1'b1;
  logic heat_in = 1'b0;
  logic warn_in = 1'b0;
  logic [1:0] open_b = '0, open_a = '0, gnd_b = '0, gnd_a = '0;
  logic [1:0] ol_b, ol_a, sh_b, sh_a;
  mds_pins_s pins;
  mds_axis_meas_s [1:0] meas;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;

  always #5 ref_clk = ~ref_clk;
  assign pins = {en_low, heat_in, warn_in, ol_b, ol_a, sh_b, sh_a};

  mds_top mds_top_inst (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .bus(bus),
    .reg_rdata(reg_rdata), .pins(pins), .axis_meas(meas), .driver_on(driver_on), .irq(irq));
  mds_coil_model mds_coil_model_inst (.ref_clk(ref_clk), .driver_on(driver_on),
    .open_b(open_b), .open_a(open_a), .gnd_b(gnd_b), .gnd_a(gnd_a),
    .open_load_b(ol_b), .open_load_a(ol_a), .short_b_det(sh_b), .short_a_det(sh_a));

  task automatic test_done();
    if (fail_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  // The whole sequence needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      fail_count = fail_count + 1;
      test_done();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Pins pass a synchroniser and filter, about five cycles
  task automatic settle();
    repeat (8) @(posedge ref_clk);
    #1;
  endtask : settle

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    @(posedge ref_clk);
    bus <= '{addr: {idx, 2'b00}, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
    @(posedge ref_clk);
    bus <= '{addr: {idx, 2'b00}, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1;
    check($sformatf("reg %h", idx), reg_rdata, exp);
  endtask : rchk

  task automatic drv_chk(input logic [1:0] exp);
    check("driver_on", {30'h0, driver_on}, {30'h0, exp});
  endtask : drv_chk

  initial begin
    meas[0] = '{standstill: 1'b1, load_measurement_result: 10'h3FF, speed_stall: 1'b0,
      current_scale: 5'h15};
    meas[1] = '{standstill: 1'b0, load_measurement_result: 10'h200, speed_stall: 1'b0,
      current_scale: 5'h0A};
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    settle();
    rchk(`MDS_IDX_STATUS_AX1, AX1);
    rchk(`MDS_IDX_STATUS_AX2, AX2);
    drv_chk(2'b00);
    wr(`MDS_IDX_STATUS_AX1, 32'hFFFF_FFFF);
    rchk(`MDS_IDX_STATUS_AX1, AX1);
    rchk(8'hFC, 32'h0);
    @(posedge ref_clk) meas[0].load_measurement_result <= 10'h000;
    settle();
    rchk(`MDS_IDX_STATUS_AX1, AX1 | B_STALL);
    @(posedge ref_clk) meas[0].load_measurement_result <= 10'h001;
    settle();
    rchk(`MDS_IDX_STATUS_AX1, AX1);
    @(posedge ref_clk) meas[1].speed_stall <= 1'b1;
    settle();
    rchk(`MDS_IDX_STATUS_AX2, AX2);
    wr(`MDS_IDX_CTRL_AX2, 32'h15);
    settle();
    rchk(`MDS_IDX_STATUS_AX2, AX2 | B_STALL);
    @(posedge ref_clk) meas[1].speed_stall <= 1'b0;
    wr(`MDS_IDX_CTRL_AX1, 32'h5);
    @(posedge ref_clk) en_low <= 1'b0;
    settle();
    drv_chk(2'b11);
    // Open load is judged while axis 1 stands still; the open bits do not depend on motion
    @(posedge ref_clk) {open_b[0], open_a[0]} <= 2'b11;
    settle();
    rchk(`MDS_IDX_STATUS_AX1, AX1 | B_OB | B_OA);
    drv_chk(2'b11);
    @(posedge ref_clk) {open_b[0], open_a[0]} <= 2'b00;
    @(posedge ref_clk) gnd_a[0] <= 1'b1;
    settle();
    drv_chk(2'b10);
    rchk(`MDS_IDX_STATUS_AX1, AX1 | B_SA);
    @(posedge ref_clk) gnd_a[0] <= 1'b0;
    settle();
    rchk(`MDS_IDX_STATUS_AX1, AX1 | B_SA);
    rchk(`MDS_IDX_STATUS_AX1, AX1 | B_SA);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(`MDS_IDX_IRQ_MASK, 32'h1);
    settle();
    check("irq raised", {31'h0, irq}, 32'h1);
    wr(`MDS_IDX_IRQ_STATUS, 32'h1);
    settle();
    check("irq cleared", {31'h0, irq}, 32'h0);
    wr(`MDS_IDX_CTRL_AX1, 32'h0);
    settle();
    rchk(`MDS_IDX_STATUS_AX1, AX1);
    drv_chk(2'b10);
    wr(`MDS_IDX_CTRL_AX1, 32'h5);
    @(posedge ref_clk) gnd_b[1] <= 1'b1;
    settle();
    drv_chk(2'b01);
    rchk(`MDS_IDX_STATUS_AX2, AX2 | B_SB);
    @(posedge ref_clk) gnd_b[1] <= 1'b0;
    @(posedge ref_clk) en_low <= 1'b1;
    settle();
    @(posedge ref_clk) en_low <= 1'b0;
    settle();
    rchk(`MDS_IDX_STATUS_AX2, AX2);
    drv_chk(2'b11);
    @(posedge ref_clk) warn_in <= 1'b1;
    settle();
    rchk(`MDS_IDX_STATUS_AX1, AX1 | B_PW);
    rchk(`MDS_IDX_STATUS_AX2, AX2 | B_PW);
    drv_chk(2'b11);
    @(posedge ref_clk) heat_in <= 1'b1;
    settle();
    drv_chk(2'b00);
    rchk(`MDS_IDX_STATUS_AX2, AX2 | B_PW | B_HOT);
    @(posedge ref_clk) heat_in <= 1'b0;
    settle();
    drv_chk(2'b00);
    rchk(`MDS_IDX_STATUS_AX1, AX1 | B_PW | B_HOT);
    @(posedge ref_clk) warn_in <= 1'b0;
    settle();
    rchk(`MDS_IDX_STATUS_AX1, AX1);
    drv_chk(2'b11);
    // Short 2, both stalls, overheat and pre-warning left pending; short 1 was cleared
    rchk(`MDS_IDX_IRQ_STATUS, 32'h3E);
    rchk(`MDS_IDX_IRQ_MASK, 32'h1);
    // A write while the clock enable is low must not land
    @(posedge ref_clk) clk_en <= 1'b0;
    wr(`MDS_IDX_CTRL_AX1, 32'h0);
    @(posedge ref_clk) clk_en <= 1'b1;
    settle();
    drv_chk(2'b11);
    rchk(`MDS_IDX_CTRL_AX1, 32'h5);
    test_done();
  end
endmodule : mds_top_tb
